//--- common/pqr_consts.vh
/*
 * Constants for the port and protocol query responder: message codes,
 * field positions, reply lengths and upper protocol code values.
 * Assumes byte-serial message streams from the surrounding transport.
 */
`ifndef PQR_CONSTS_VH
`define PQR_CONSTS_VH

// ---------------------------------------------------------------
// Message codes
// ---------------------------------------------------------------
`define PQR_CODE_PORT_QRY 8'h0A
`define PQR_CODE_PORT_RPL 8'h0B
`define PQR_CODE_PROT_QRY 8'h08
`define PQR_CODE_PROT_RPL 8'h09

// ---------------------------------------------------------------
// Lengths and positions
// ---------------------------------------------------------------
`define PQR_PORT_QRY_LEN 5'h09
`define PQR_PROT_QRY_LEN 5'h08
`define PQR_PORT_RPL_LEN 5'h12
`define PQR_PROT_RPL_LEN 5'h0F
`define PQR_LIST_START 5'h04
`define PQR_LIST_LEN 4'hB
`define PQR_CLEAR_BIT 0

// ---------------------------------------------------------------
// Counter and upper protocol codes
// ---------------------------------------------------------------
`define PQR_CNT_MAX 16'hFFFF
`define PQR_ULP_QUERY 8'h00
`define PQR_ULP_NONE 8'h01
`define PQR_ULP_VENDOR 8'h02
`define PQR_ULP_STD_LO 8'h80
`define PQR_ULP_STD_HI 8'h83
`define PQR_ULP_VSPEC_LO 8'hFB

`endif

//--- hdl/pqr_rec_counter.v
/*
 * Saturating link recovery counter for one port.
 * Assumes event and clear inputs are one-cycle pulses on sys_clk.
 */
`timescale 1ns/1ps
`include "pqr_consts.vh"

module pqr_rec_counter (
  sys_clk,
  rst_n,
  recovery_start,
  reset_frame,
  clear_req,
  count
);
  input wire sys_clk;
  input wire rst_n;
  input wire recovery_start;
  input wire reset_frame;
  input wire clear_req;
  output wire [15:0] count;

  reg [15:0] cnt_ff;
  reg [15:0] nxt_cnt;

  // ---------------------------------------------------------------
  // Count, saturate, clear
  // ---------------------------------------------------------------
  always @* begin
    nxt_cnt = cnt_ff;
    if (reset_frame || clear_req) begin
      nxt_cnt = 16'h0000;
    end
    if (recovery_start && (nxt_cnt != `PQR_CNT_MAX)) begin
      nxt_cnt = nxt_cnt + 16'h0001;
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 16'h0000;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign count = cnt_ff;
endmodule

//--- hdl/pqr_responder.v
/*
 * Query responder: parses port and protocol query messages arriving one
 * byte per cycle, and streams the matching reply or an invalid-field
 * response. Assumes the transport frames the messages, delivers bytes
 * with rx_valid/rx_last, drains tx bytes under tx_ready, and takes the
 * reply port and return path from the side outputs during the reply.
 */
// Operation
// - Port query 0Ah answered by reply 0Bh
// - Reply tag copies query tag
// - Reply path is query return path
// - Clear flag zeroes counter after reply
// - Recovery count saturates at FFFFh
// - Reply bytes 6,7 carry quotas
// - Byte 8 check option, reflect, mode
// - Bytes 10-11 carry alarm threshold
// - Capability bits follow port ability
// - One current-rate bit, none if down
// - Window size is buffers minus one
// - Protocol query 08h answered by 09h
// - Protocol reply leaves arrival port
// - List eleven bytes, packed, zero filled
// - Standard one byte, vendor five bytes
// - Listed protocol codes are distinct
// - Protocol reply path is return path
// - Protocol reply tag copies query tag
// - Upper protocol codes follow encoding
`timescale 1ns/1ps
`include "pqr_consts.vh"

module pqr_responder (
  input wire sys_clk,
  input wire rst_n,
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire rx_last,
  input wire [7:0] rx_port,
  output wire tx_valid,
  output wire [7:0] tx_data,
  output wire tx_last,
  input wire tx_ready,
  output wire tx_invalid,
  output wire [7:0] tx_port,
  output wire [31:0] tx_path,
  output wire [15:0] tx_tag,
  input wire recovery_start,
  input wire reset_frame,
  input wire [7:0] first_quota,
  input wire [7:0] second_quota,
  input wire data_check_option,
  input wire reflect_setting,
  input wire [1:0] port_mode,
  input wire [15:0] alarm_threshold,
  input wire fast_rate_capable,
  input wire slow_rate_capable,
  input wire port_operational,
  input wire fast_rate_active,
  input wire [15:0] window_size,
  input wire [87:0] protocol_list,
  output wire busy,
  output wire [15:0] link_recovery_count
);

  localparam ST_RX = 2'd0;
  localparam ST_DROP = 2'd1;
  localparam ST_TX = 2'd2;

  localparam KIND_PORT = 1'b0;
  localparam KIND_PROT = 1'b1;

  reg [1:0] state_ff, nxt_state;
  reg [4:0] idx_ff, nxt_idx;
  reg kind_ff, nxt_kind;
  reg bad_ff, nxt_bad;
  reg clr_ff, nxt_clr;
  reg [15:0] tag_ff, nxt_tag;
  reg [31:0] path_ff, nxt_path;
  reg [7:0] port_ff, nxt_port;
  reg [15:0] snap_cnt_ff, nxt_snap_cnt;
  reg [7:0] data_ff, nxt_data;
  reg last_ff, nxt_last;
  reg clear_pulse;
  reg [7:0] reply_byte;

  wire [4:0] reply_len;
  wire [15:0] count_now;
  wire [7:0] speed_now;
  wire list_ok;

  // ---------------------------------------------------------------
  // Recovery counter
  // ---------------------------------------------------------------
  pqr_rec_counter u_counter (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .recovery_start(recovery_start),
    .reset_frame(reset_frame),
    .clear_req(clear_pulse),
    .count(count_now)
  );

  assign link_recovery_count = count_now;

  // ---------------------------------------------------------------
  // Protocol list check
  // ---------------------------------------------------------------
  // Walks the configured list: each entry must hold a valid reply code,
  // codes must not repeat, vendor entries span five bytes and the
  // tail from the first entry whose code byte is zero must stay zero.
  function list_valid;
    input [87:0] lst;
    integer i;
    integer j;
    integer skip;
    reg ended;
    reg ok;
    reg [7:0] b;
    reg [7:0] c;
    begin
      ok = 1'b1;
      ended = 1'b0;
      skip = 0;
      for (i = 0; i < 11; i = i + 1) begin
        b = lst[87 - 8 * i -: 8];
        if (skip > 0) begin
          skip = skip - 1;
        end else if (ended || b == `PQR_ULP_QUERY) begin
          ended = 1'b1;
          if (b != 8'h00) begin
            ok = 1'b0;
          end
        end else begin
          if (!(b == `PQR_ULP_VENDOR || b == `PQR_ULP_STD_LO ||
                b == 8'h82 || b == `PQR_ULP_STD_HI || b >= `PQR_ULP_VSPEC_LO)) begin
            ok = 1'b0;
          end
          if (b == `PQR_ULP_VENDOR || b >= `PQR_ULP_VSPEC_LO) begin
            skip = 4;
            if (i > 6) begin
              ok = 1'b0;
            end
          end
          for (j = 0; j < 11; j = j + 1) begin
            c = lst[87 - 8 * j -: 8];
            if (j > i && c == b && list_head(lst, j)) begin
              ok = 1'b0;
            end
          end
        end
      end
      list_valid = ok;
    end
  endfunction

  // True when byte k of the list starts an entry
  function list_head;
    input [87:0] lst;
    input integer k;
    integer i;
    integer skip;
    reg [7:0] b;
    reg hd;
    begin
      hd = 1'b0;
      skip = 0;
      for (i = 0; i < 11; i = i + 1) begin
        b = lst[87 - 8 * i -: 8];
        if (skip > 0) begin
          skip = skip - 1;
        end else begin
          if (i == k) begin
            hd = 1'b1;
          end
          if (b == `PQR_ULP_VENDOR || b >= `PQR_ULP_VSPEC_LO) begin
            skip = 4;
          end
        end
      end
      list_head = hd;
    end
  endfunction

  assign list_ok = list_valid(protocol_list);
  assign reply_len = (kind_ff == KIND_PORT) ? `PQR_PORT_RPL_LEN : `PQR_PROT_RPL_LEN;

  assign speed_now = {6'h00, fast_rate_active & port_operational,
                      ~fast_rate_active & port_operational};

  // ---------------------------------------------------------------
  // Reply byte selection
  // ---------------------------------------------------------------
  always @* begin
    reply_byte = 8'h00;
    if (kind_ff == KIND_PORT) begin
      case (nxt_idx)
        5'd0: reply_byte = `PQR_CODE_PORT_RPL;
        5'd2: reply_byte = tag_ff[15:8];
        5'd3: reply_byte = tag_ff[7:0];
        5'd4: reply_byte = snap_cnt_ff[15:8];
        5'd5: reply_byte = snap_cnt_ff[7:0];
        5'd6: reply_byte = first_quota;
        5'd7: reply_byte = second_quota;
        5'd8: reply_byte = {data_check_option, reflect_setting, 4'h0, port_mode};
        5'd10: reply_byte = alarm_threshold[15:8];
        5'd11: reply_byte = alarm_threshold[7:0];
        5'd13: reply_byte = {6'h00, fast_rate_capable, slow_rate_capable};
        5'd15: reply_byte = speed_now;
        5'd16: reply_byte = window_size[15:8];
        5'd17: reply_byte = window_size[7:0];
        default: reply_byte = 8'h00;
      endcase
    end else begin
      case (nxt_idx)
        5'd0: reply_byte = `PQR_CODE_PROT_RPL;
        5'd2: reply_byte = tag_ff[15:8];
        5'd3: reply_byte = tag_ff[7:0];
        default: begin
          if (nxt_idx >= `PQR_LIST_START && nxt_idx < `PQR_LIST_START + `PQR_LIST_LEN) begin
            reply_byte = protocol_list[87 - 8 * (nxt_idx - `PQR_LIST_START) -: 8];
          end
        end
      endcase
    end
    nxt_data = reply_byte;
    nxt_last = (nxt_idx == reply_len - 5'd1);
  end

  // ---------------------------------------------------------------
  // Receive and transmit sequencing
  // ---------------------------------------------------------------
  always @* begin
    nxt_state = state_ff;
    nxt_idx = idx_ff;
    nxt_kind = kind_ff;
    nxt_bad = bad_ff;
    nxt_clr = clr_ff;
    nxt_tag = tag_ff;
    nxt_path = path_ff;
    nxt_port = port_ff;
    nxt_snap_cnt = snap_cnt_ff;
    clear_pulse = 1'b0;
    case (state_ff)
      ST_RX: begin
        if (rx_valid) begin
          nxt_idx = idx_ff + 5'd1;
          case (idx_ff)
            5'd0: begin
              nxt_port = rx_port;
              nxt_bad = 1'b0;
              nxt_clr = 1'b0;
              if (rx_data == `PQR_CODE_PORT_QRY) begin
                nxt_kind = KIND_PORT;
              end else if (rx_data == `PQR_CODE_PROT_QRY) begin
                nxt_kind = KIND_PROT;
              end else begin
                nxt_state = ST_DROP;
              end
            end
            5'd1: begin
              if (kind_ff == KIND_PORT && rx_data != rx_port) begin
                nxt_bad = 1'b1;
              end
              if (kind_ff == KIND_PROT && rx_data != 8'h00) begin
                nxt_bad = 1'b1;
              end
            end
            5'd2: nxt_tag[15:8] = rx_data;
            5'd3: nxt_tag[7:0] = rx_data;
            5'd4: nxt_path[31:24] = rx_data;
            5'd5: nxt_path[23:16] = rx_data;
            5'd6: nxt_path[15:8] = rx_data;
            5'd7: nxt_path[7:0] = rx_data;
            5'd8: begin
              nxt_clr = rx_data[`PQR_CLEAR_BIT];
              if (rx_data[7:1] != 7'h00) begin
                nxt_bad = 1'b1;
              end
            end
            default: nxt_bad = 1'b1;
          endcase
          if (rx_last && nxt_state == ST_RX) begin
            if ((kind_ff == KIND_PORT && idx_ff != `PQR_PORT_QRY_LEN - 5'd1) ||
                (kind_ff == KIND_PROT && idx_ff != `PQR_PROT_QRY_LEN - 5'd1) ||
                idx_ff == 5'd0) begin
              nxt_bad = 1'b1;
            end
            if (kind_ff == KIND_PROT && !list_ok) begin
              nxt_bad = 1'b1;
            end
            nxt_state = ST_TX;
            nxt_idx = 5'd0;
            nxt_snap_cnt = count_now;
          end else if (rx_last) begin
            nxt_state = ST_RX;
            nxt_idx = 5'd0;
          end
        end
      end
      ST_DROP: begin
        if (rx_valid && rx_last) begin
          nxt_state = ST_RX;
          nxt_idx = 5'd0;
        end
      end
      ST_TX: begin
        if (bad_ff) begin
          nxt_state = ST_RX; // invalid-field response raised via tx_invalid
          nxt_idx = 5'd0;
        end else if (tx_ready) begin
          nxt_idx = idx_ff + 5'd1;
          if (idx_ff == reply_len - 5'd1) begin
            nxt_state = ST_RX;
            nxt_idx = 5'd0;
            clear_pulse = (kind_ff == KIND_PORT) && clr_ff;
          end
        end
      end
      default: begin
        nxt_state = ST_RX;
        nxt_idx = 5'd0;
      end
    endcase
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_RX;
      idx_ff <= 5'd0;
      kind_ff <= KIND_PORT;
      bad_ff <= 1'b0;
      clr_ff <= 1'b0;
      tag_ff <= 16'h0000;
      path_ff <= 32'h0000_0000;
      port_ff <= 8'h00;
      snap_cnt_ff <= 16'h0000;
      data_ff <= 8'h00;
      last_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      idx_ff <= nxt_idx;
      kind_ff <= nxt_kind;
      bad_ff <= nxt_bad;
      clr_ff <= nxt_clr;
      tag_ff <= nxt_tag;
      path_ff <= nxt_path;
      port_ff <= nxt_port;
      snap_cnt_ff <= nxt_snap_cnt;
      data_ff <= nxt_data;
      last_ff <= nxt_last;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign tx_valid = (state_ff == ST_TX) && !bad_ff;
  assign tx_data = data_ff;
  assign tx_last = tx_valid && last_ff;
  assign tx_invalid = (state_ff == ST_TX) && bad_ff;
  assign tx_port = port_ff;
  assign tx_path = path_ff;
  assign tx_tag = tag_ff;
  assign busy = (state_ff == ST_TX);
endmodule

//--- dv/pqr_resp_props.sv
/* Checker for the query responder ports.
   Assumes it is bound to every pqr_responder instance. */
`timescale 1ns/1ps
module pqr_resp_props (
  input wire sys_clk,
  input wire rst_n,
  input wire tx_valid,
  input wire [7:0] tx_data,
  input wire tx_last,
  input wire tx_ready,
  input wire tx_invalid,
  input wire [7:0] tx_port,
  input wire [31:0] tx_path,
  input wire [15:0] tx_tag,
  input wire recovery_start,
  input wire reset_frame,
  input wire [7:0] first_quota,
  input wire port_operational,
  input wire fast_rate_active,
  input wire busy,
  input wire [15:0] link_recovery_count
);
  // ------
  // Reply byte position and reply code
  // ------
  logic [4:0] idx_ff;
  logic [7:0] code_ff;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_ff <= 5'h00;
      code_ff <= 8'h00;
    end else begin
      if (tx_valid && idx_ff == 5'h00)
        code_ff <= tx_data;
      if (!tx_valid)
        idx_ff <= 5'h00;
      else if (tx_ready)
        idx_ff <= idx_ff + 5'h01;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ------
  // Properties
  // ------
  first_code_a: assert property ($rose(tx_valid) |-> tx_data == 8'h0B || tx_data == 8'h09)
    else $error("reply opens with a wrong code");
  inv_pulse_a: assert property (tx_invalid |=> !tx_invalid)
    else $error("invalid-field strobe longer than one cycle");
  byte_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("reply byte changed while stalled");
  ctx_hold_a: assert property (busy && $past(busy) |-> $stable({tx_tag, tx_path, tx_port}))
    else $error("tag, path or port changed during reply");
  count_inc_a: assert property (!busy && recovery_start && !reset_frame && link_recovery_count != 16'hFFFF
    |=> link_recovery_count == $past(link_recovery_count) + 16'h0001)
    else $error("recovery count did not step by one");
  count_sat_a: assert property (link_recovery_count == 16'hFFFF && recovery_start && !busy && !reset_frame
    |=> link_recovery_count == 16'hFFFF)
    else $error("recovery count left saturation");
  count_keep_a: assert property (!busy && !recovery_start && !reset_frame |=> $stable(link_recovery_count))
    else $error("recovery count changed without cause");
  frame_clear_a: assert property (reset_frame && !recovery_start |=> link_recovery_count == 16'h0000)
    else $error("reset frame did not zero the count");
  speed_bits_a: assert property (tx_valid && idx_ff == 5'h0F && code_ff == 8'h0B |-> tx_data == {6'h00,
    port_operational && fast_rate_active, port_operational && !fast_rate_active})
    else $error("current speed byte wrong");
  quota_byte_a: assert property (tx_valid && idx_ff == 5'h06 && code_ff == 8'h0B |-> tx_data == first_quota)
    else $error("first quota byte wrong");
  last_pos_a: assert property (tx_valid && tx_last |-> idx_ff == (code_ff == 8'h0B ? 5'h11 : 5'h0E))
    else $error("reply length wrong");
endmodule
bind pqr_responder pqr_resp_props u_props (.sys_clk, .rst_n, .tx_valid, .tx_data, .tx_last, .tx_ready,
  .tx_invalid, .tx_port, .tx_path, .tx_tag, .recovery_start, .reset_frame, .first_quota,
  .port_operational, .fast_rate_active, .busy, .link_recovery_count);

//--- dv/pqr_cfg_node.sv
/* Configuring node model: sends queries a byte a cycle, sinks replies.
   Assumes the responder is idle when a query starts. */
`timescale 1ns/1ps
module pqr_cfg_node (
  input wire logic sys_clk,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_last,
  output logic tx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_invalid
);
  logic [15:0] cur_tag = 16'h0100;
  logic slow = 1'b0;
  initial begin
    rx_valid = 1'b0;
    rx_last = 1'b0;
    rx_data = 8'h00;
  end
  // Random stalls while slow is set
  always @(posedge sys_clk)
    tx_ready <= slow ? 1'($urandom % 2) : 1'b1;
  task automatic send(input logic [7:0] m[$]);
    foreach (m[i]) begin
      @(posedge sys_clk);
      rx_valid <= 1'b1;
      rx_data <= m[i];
      rx_last <= (i == m.size() - 1);
    end
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_data <= ~rx_data;
  endtask
  // A fresh tag per query keeps outstanding tags distinct
  task automatic query(input logic [7:0] code, input logic [7:0] b1, input logic [31:0] path,
    input logic [7:0] b8, input bit nine);
    logic [7:0] m[$];
    cur_tag = cur_tag + 16'h0001;
    m = '{code, b1, cur_tag[15:8], cur_tag[7:0], path[31:24], path[23:16], path[15:8], path[7:0]};
    if (nine)
      m.push_back(b8);
    send(m);
  endtask
  task automatic take(output logic [7:0] r[$], output logic inv);
    int n;
    r = {};
    inv = 1'b0;
    n = 0;
    while (n < 100) begin
      @(posedge sys_clk);
      n++;
      if (tx_invalid === 1'b1)
        inv = 1'b1;
      if (tx_valid && tx_ready) begin
        r.push_back(tx_data);
        if (tx_last)
          n = 100;
      end
      if (inv)
        n = 100;
    end
  endtask
endmodule

//--- dv/testbench.sv
/* Self-checking bench for the query responder.
   Assumes the configuring node model drives the query side. */
`timescale 1ns/1ps
`include "pqr_consts.vh"
module testbench;
  typedef logic [7:0] pqr_bytes_t[$];
  localparam logic [23:0] VID = 24'h12_3456; // Arbitrary organization code
  logic sys_clk, rst_n = 1'b0, recovery_start = 1'b0, reset_frame = 1'b0, inv;
  logic data_check_option = 1'b0, reflect_setting = 1'b0, fast_rate_capable = 1'b0;
  logic slow_rate_capable = 1'b0, port_operational = 1'b0, fast_rate_active = 1'b0;
  logic [7:0] rx_port = 8'h00, first_quota = 8'h00, second_quota = 8'h00, rx_data, tx_data, tx_port;
  logic [1:0] port_mode = 2'h0;
  logic [15:0] alarm_threshold = 16'h0000, window_size = 16'h0000, tx_tag, link_recovery_count, cnt;
  logic [87:0] protocol_list = 88'h0;
  logic [31:0] tx_path, path;
  logic rx_valid, rx_last, tx_valid, tx_last, tx_ready, tx_invalid, busy;
  logic [87:0] lists [5] = '{{8'h80, 8'h02, VID, 8'h01, 8'h82, 32'h0000_0000},
    {8'hFB, VID, 8'h07, 8'hFF, VID, 8'h08, 8'h83}, {8'h80, 8'h80, 72'h0}, {8'h81, 80'h0},
    {8'h80, 8'h00, 8'h82, 64'h0}};
  logic [7:0] bc [5] = '{8'h0A, 8'h0A, 8'h0A, 8'h08, 8'h0C};
  logic [7:0] bx [5] = '{8'h01, 8'h00, 8'h00, 8'h01, 8'h00};
  logic [7:0] b8v [5] = '{8'h00, 8'h02, 8'h00, 8'h00, 8'h00};
  bit nn [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  pqr_bytes_t r, e;
  int errors = 0, n_compared = 0, k;
  pqr_responder u_dut (.sys_clk, .rst_n, .rx_valid, .rx_data, .rx_last, .rx_port, .tx_valid,
    .tx_data, .tx_last, .tx_ready, .tx_invalid, .tx_port, .tx_path, .tx_tag, .recovery_start,
    .reset_frame, .first_quota, .second_quota, .data_check_option, .reflect_setting, .port_mode,
    .alarm_threshold, .fast_rate_capable, .slow_rate_capable, .port_operational, .fast_rate_active,
    .window_size, .protocol_list, .busy, .link_recovery_count);
  pqr_cfg_node u_node (.sys_clk, .rx_valid, .rx_data, .rx_last, .tx_ready, .tx_valid, .tx_data,
    .tx_last, .tx_invalid);
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // ------
  // Checking and expectations
  // ------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cmp(input pqr_bytes_t got, input pqr_bytes_t exp);
    check(got.size(), exp.size());
    foreach (exp[i])
      check(got[i], exp[i]);
  endtask
  function automatic pqr_bytes_t port_rpl(input logic [15:0] tag, input logic [15:0] c);
    return '{`PQR_CODE_PORT_RPL, 8'h00, tag[15:8], tag[7:0], c[15:8], c[7:0], first_quota,
      second_quota, {data_check_option, reflect_setting, 4'h0, port_mode}, 8'h00,
      alarm_threshold[15:8], alarm_threshold[7:0], 8'h00, {6'h00, fast_rate_capable,
      slow_rate_capable}, 8'h00, {6'h00, port_operational & fast_rate_active,
      port_operational & ~fast_rate_active}, window_size[15:8], window_size[7:0]};
  endfunction
  task automatic rnd_cfg();
    @(posedge sys_clk);
    {first_quota, second_quota, alarm_threshold} <= $urandom;
    {window_size, rx_port, port_mode, data_check_option, reflect_setting} <= 28'($urandom);
    {fast_rate_capable, slow_rate_capable} <= 2'($urandom);
    // Let the new port number land before a query copies it
    @(posedge sys_clk);
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      recovery_start <= 1'b1;
      @(posedge sys_clk);
      recovery_start <= 1'b0;
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge sys_clk);
    errors++;
    report_and_stop();
  end
  // ------
  // Scenarios
  // ------
  initial begin
    void'($urandom(10));
    cnt = 16'h0000;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rnd_cfg();
      port_operational <= i[1];
      fast_rate_active <= i[2];
      u_node.slow = i[0];
      k = $urandom % 4;
      pulse(k);
      cnt = cnt + 16'(k);
      path = $urandom;
      u_node.query(8'h0A, rx_port, path, {7'h00, i[1]}, 1'b1);
      u_node.take(r, inv);
      cmp(r, port_rpl(u_node.cur_tag, cnt));
      check(tx_tag, u_node.cur_tag);
      check(tx_path, path);
      @(posedge sys_clk);
      if (i[1])
        cnt = 16'h0000;
      check(link_recovery_count, cnt);
    end
    for (int i = 0; i < 5; i++) begin
      u_node.query(bc[i], i < 3 ? rx_port ^ bx[i] : bx[i], 32'h0, b8v[i], nn[i]);
      u_node.take(r, inv);
      check(inv, i < 4);
      check(r.size(), 0);
    end
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk);
      protocol_list <= lists[i];
      rx_port <= 8'($urandom);
      path = $urandom;
      u_node.query(8'h08, 8'h00, path, 8'h00, 1'b0);
      u_node.take(r, inv);
      check(inv, i > 1);
      if (i < 2) begin
        e = '{`PQR_CODE_PROT_RPL, 8'h00, u_node.cur_tag[15:8], u_node.cur_tag[7:0]};
        for (int j = 10; j >= 0; j--)
          e.push_back(lists[i][j*8 +: 8]);
        cmp(r, e);
      end
      check(tx_port, rx_port);
      check(tx_path, path);
    end
    @(posedge sys_clk);
    recovery_start <= 1'b1;
    repeat (65540) @(posedge sys_clk);
    recovery_start <= 1'b0;
    @(posedge sys_clk);
    check(link_recovery_count, 16'hFFFF);
    u_node.query(8'h0A, rx_port, 32'h0, 8'h01, 1'b1);
    u_node.take(r, inv);
    cmp(r, port_rpl(u_node.cur_tag, 16'hFFFF));
    @(posedge sys_clk);
    check(link_recovery_count, 16'h0000);
    pulse(3);
    @(posedge sys_clk);
    check(link_recovery_count, 16'h0003);
    reset_frame <= 1'b1;
    @(posedge sys_clk);
    reset_frame <= 1'b0;
    @(posedge sys_clk);
    check(link_recovery_count, 16'h0000);
    report_and_stop();
  end
endmodule
